// >>> rtl/rcc_top.sv
`timescale 1ns/1ps
module rcc_top #(
    parameter logic [32:0] VPP_CYCLES_P = 33'(rcc_pkg::VPP_CYCLES)
) (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [7:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    input  wire logic               rt_data_valid,
    input  wire logic [31:0]        rt_data,
    output logic                    tx_data_valid,
    output logic [31:0]             tx_data,
    output rcc_pkg::rcc_out_t       ctl_out,
    output logic                    irq
);

    localparam int unsigned N = rcc_pkg::NUM_CH;

    logic [7:0]  awaddr_q, awaddr_d, araddr_q, araddr_d;
    logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
    logic [2*N-1:0] relay_q, relay_d;
    logic        vpp_q, vpp_d, led_q, led_d, rt_q, rt_d;
    logic [32:0] vpp_cnt_q, vpp_cnt_d;
    logic [4:0]  warm_cnt_q, warm_cnt_d;
    logic        warm_q, warm_d, cal_q, cal_d;
    logic [1:0]  cfg_res_q, cfg_res_d;
    logic [rcc_pkg::IRQ_W-1:0] ist_q, ist_d, imsk_q, imsk_d, ev;
    logic        txv_q, txv_d;
    logic [31:0] txd_q, txd_d;
    logic        irq_q, irq_d;
    logic        wr_fire, rd_fire;
    logic        awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
    logic [31:0] wv;
    logic [2*N-1:0] relay_wr;

    // A write executes once both address and data are held; response follows both.
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign wv      = wdata_q;

    // Per-channel relay update; each channel only takes its own field when its enable is set.
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_ch
            always_comb begin
                relay_wr[2*g +: 2] = relay_q[2*g +: 2];
                if (wv[rcc_pkg::RELAY_EN_POS + g] && wv[2*g +: 2] != 2'h3) begin
                    relay_wr[2*g +: 2] = wv[2*g +: 2];
                end
            end
        end
    endgenerate

    // Bus channel next values.
    always_comb begin
        awaddr_d  = awaddr_q;
        wdata_d   = wdata_q;
        aw_have_d = aw_have_q;
        w_have_d  = w_have_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        araddr_d  = araddr_q;
        rvalid_d  = rvalid_q;
        rresp_d   = rresp_q;
        if (s_axi_awvalid && s_axi_awready) begin
            awaddr_d  = s_axi_awaddr;
            aw_have_d = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wdata_d  = s_axi_wdata;
            w_have_d = 1'b1;
        end
        if (wr_fire) begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = (awaddr_q == rcc_pkg::OFF_STATUS || awaddr_q > rcc_pkg::OFF_IRQ_MSK) ? 2'h2 : 2'h0;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (rd_fire) begin
            araddr_d = s_axi_araddr;
            rvalid_d = 1'b1;
            rresp_d  = (s_axi_araddr > rcc_pkg::OFF_IRQ_MSK) ? 2'h2 : 2'h0;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        // Readies come from the next state so that they leave a flop yet never accept while a response is pending.
        awready_d = !aw_have_d && !bvalid_d;
        wready_d  = !w_have_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    // Read data mux; reading interrupt status clears it.
    always_comb begin
        rdata_d = rdata_q;
        if (rd_fire) begin
            unique case (s_axi_araddr)
                rcc_pkg::OFF_RELAY:   rdata_d = 32'(relay_q);
                rcc_pkg::OFF_CTRL:    rdata_d = 32'({rt_q, led_q, 2'h0} | 32'(vpp_q));
                rcc_pkg::OFF_CFG:     rdata_d = 32'(cfg_res_q);
                rcc_pkg::OFF_STATUS:  rdata_d = {warm_q, cal_q, vpp_cnt_q[29:0]};
                rcc_pkg::OFF_IRQ_ST:  rdata_d = 32'(ist_q);
                rcc_pkg::OFF_IRQ_MSK: rdata_d = 32'(imsk_q);
                default:              rdata_d = 32'h0;
            endcase
        end
    end

    // Control state next values.
    always_comb begin
        relay_d    = relay_q;
        vpp_d      = vpp_q;
        vpp_cnt_d  = vpp_cnt_q;
        led_d      = led_q;
        rt_d       = rt_q;
        warm_cnt_d = warm_cnt_q;
        warm_d     = 1'b0;
        cal_d      = 1'b0;
        cfg_res_d  = cfg_res_q;
        imsk_d     = imsk_q;
        ev         = '0;
        // The supply timer counts down and switches itself off at zero.
        if (vpp_q) begin
            if (vpp_cnt_q <= 33'h1) begin
                vpp_d = 1'b0;
                vpp_cnt_d = 33'h0;
                ev[rcc_pkg::IRQ_VPP_EXP] = 1'b1;
            end else begin
                vpp_cnt_d = vpp_cnt_q - 33'h1;
            end
        end
        // Warm reset pulse stretched so slow firmware sees it.
        if (warm_cnt_q != 5'h0) begin
            warm_cnt_d = warm_cnt_q - 5'h1;
            warm_d     = 1'b1;
        end
        if (wr_fire) begin
            unique case (awaddr_q)
                rcc_pkg::OFF_RELAY: relay_d = relay_wr;
                rcc_pkg::OFF_CTRL: begin
                    led_d = wv[rcc_pkg::CTRL_LED_POS];
                    rt_d  = wv[rcc_pkg::CTRL_RT_POS];
                    if (wv[rcc_pkg::CTRL_VPP_OFF]) begin
                        vpp_d     = 1'b0;
                        vpp_cnt_d = 33'h0;
                    end else if (wv[rcc_pkg::CTRL_VPP_ON]) begin
                        vpp_d     = 1'b1;
                        vpp_cnt_d = VPP_CYCLES_P;
                    end
                    if (wv[rcc_pkg::CTRL_CAL_DONE]) begin
                        relay_d = '0;
                        ev[rcc_pkg::IRQ_CAL_RET] = 1'b1;
                    end
                end
                rcc_pkg::OFF_CFG: begin
                    if (wv[rcc_pkg::CFG_ARRIVE]) begin
                        cfg_res_d = {wv[rcc_pkg::CFG_VALID], !wv[rcc_pkg::CFG_VALID]};
                        ev[rcc_pkg::IRQ_CFG_ACK] = wv[rcc_pkg::CFG_VALID];
                        ev[rcc_pkg::IRQ_CFG_NAK] = !wv[rcc_pkg::CFG_VALID];
                        if (wv[rcc_pkg::CFG_VALID]) begin
                            warm_cnt_d = 5'(rcc_pkg::WARM_CYCLES);
                            cal_d      = 1'b1;
                        end
                    end
                end
                rcc_pkg::OFF_IRQ_MSK: imsk_d = wv[rcc_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
        // Sticky status: read clears, but a new event in the same cycle wins.
        ist_d = ist_q;
        if (rd_fire && s_axi_araddr == rcc_pkg::OFF_IRQ_ST) begin
            ist_d = '0;
        end
        ist_d = ist_d | ev;
        irq_d = |(ist_d & imsk_d);
        // Streaming gated by the real-time enable; time sync is not touched here.
        txv_d = rt_q && rt_data_valid;
        txd_d = rt_data_valid ? rt_data : txd_q;
    end

    // Single register stage for all state.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awaddr_q <= '0; wdata_q <= '0; aw_have_q <= 1'b0; w_have_q <= 1'b0;
            bvalid_q <= 1'b0; bresp_q <= '0; araddr_q <= '0; rvalid_q <= 1'b0;
            rresp_q <= '0; rdata_q <= '0; relay_q <= '0; vpp_q <= 1'b0;
            vpp_cnt_q <= '0; led_q <= rcc_pkg::RST_LED; rt_q <= rcc_pkg::RST_RT;
            warm_cnt_q <= '0; warm_q <= 1'b0; cal_q <= 1'b0; cfg_res_q <= '0;
            ist_q <= '0; imsk_q <= '0; txv_q <= 1'b0; txd_q <= '0; irq_q <= 1'b0;
            awready_q <= 1'b0; wready_q <= 1'b0; arready_q <= 1'b0;
        end else begin
            awaddr_q <= awaddr_d; wdata_q <= wdata_d; aw_have_q <= aw_have_d;
            w_have_q <= w_have_d; bvalid_q <= bvalid_d; bresp_q <= bresp_d;
            araddr_q <= araddr_d; rvalid_q <= rvalid_d; rresp_q <= rresp_d;
            rdata_q <= rdata_d; relay_q <= relay_d; vpp_q <= vpp_d;
            vpp_cnt_q <= vpp_cnt_d; led_q <= led_d; rt_q <= rt_d;
            warm_cnt_q <= warm_cnt_d; warm_q <= warm_d; cal_q <= cal_d;
            cfg_res_q <= cfg_res_d; ist_q <= ist_d; imsk_q <= imsk_d;
            txv_q <= txv_d; txd_q <= txd_d; irq_q <= irq_d;
            awready_q <= awready_d; wready_q <= wready_d; arready_q <= arready_d;
        end
    end

    // Readies stay low in reset and rise one edge after release, so no request is lost to reset.
    assign s_axi_awready       = awready_q;
    assign s_axi_wready        = wready_q;
    assign s_axi_arready       = arready_q;
    assign s_axi_bvalid        = bvalid_q;
    assign s_axi_bresp         = bresp_q;
    assign s_axi_rvalid        = rvalid_q;
    assign s_axi_rresp         = rresp_q;
    assign s_axi_rdata         = rdata_q;
    assign tx_data_valid       = txv_q;
    assign tx_data             = txd_q;
    assign irq                 = irq_q;
    assign ctl_out.vpp_en      = vpp_q;
    assign ctl_out.led_en      = led_q;
    assign ctl_out.rt_en       = rt_q;
    assign ctl_out.warm_rst    = warm_q;
    assign ctl_out.offset_cal  = cal_q;
    assign ctl_out.relay_sel   = relay_q;

    // Checks.
    property p_vpp_expire;
        @(posedge aclk) disable iff (!aresetn) (vpp_q && vpp_cnt_q == 33'h1) |=> !vpp_q;
    endproperty
    a_vpp_expire: assert property (p_vpp_expire) else $error("Supply did not switch off at expiry.");
    property p_vpp_off;
        @(posedge aclk) disable iff (!aresetn) (wr_fire && awaddr_q == rcc_pkg::OFF_CTRL && wv[1]) |=> !vpp_q;
    endproperty
    a_vpp_off: assert property (p_vpp_off) else $error("Off did not stop supply.");
    property p_vpp_on;
        @(posedge aclk) disable iff (!aresetn)
            (wr_fire && awaddr_q == rcc_pkg::OFF_CTRL && wv[0] && !wv[1]) |=> vpp_q && vpp_cnt_q == VPP_CYCLES_P;
    endproperty
    a_vpp_on: assert property (p_vpp_on) else $error("On did not arm timer.");
    property p_cal_ret;
        @(posedge aclk) disable iff (!aresetn) (wr_fire && awaddr_q == rcc_pkg::OFF_CTRL && wv[4]) |=> relay_q == '0;
    endproperty
    a_cal_ret: assert property (p_cal_ret) else $error("Relays not returned after calibration.");
    property p_relay_hold;
        @(posedge aclk) disable iff (!aresetn) !wr_fire |=> $stable(relay_q);
    endproperty
    a_relay_hold: assert property (p_relay_hold) else $error("Relays changed without command.");
    property p_relay_legal;
        @(posedge aclk) disable iff (!aresetn) relay_q[1:0] != 2'h3;
    endproperty
    a_relay_legal: assert property (p_relay_legal) else $error("Illegal relay path.");
    property p_relay_en;
        @(posedge aclk) disable iff (!aresetn)
            (wr_fire && awaddr_q == rcc_pkg::OFF_RELAY && !wv[16]) |=> $stable(relay_q[1:0]);
    endproperty
    a_relay_en: assert property (p_relay_en) else $error("Channel changed without enable.");
    property p_warm;
        @(posedge aclk) disable iff (!aresetn)
            (wr_fire && awaddr_q == rcc_pkg::OFF_CFG && wv[0] && wv[1]) |=> cal_q ##1 warm_q [*8];
    endproperty
    a_warm: assert property (p_warm) else $error("Accepted upload gave no warm reset.");
    property p_cfg_ans;
        @(posedge aclk) disable iff (!aresetn)
            (wr_fire && awaddr_q == rcc_pkg::OFF_CFG && wv[0]) |=> cfg_res_q == {$past(wv[1]), !$past(wv[1])};
    endproperty
    a_cfg_ans: assert property (p_cfg_ans) else $error("Upload answer wrong.");
    property p_rt_gate;
        @(posedge aclk) disable iff (!aresetn) !rt_q |=> !tx_data_valid;
    endproperty
    a_rt_gate: assert property (p_rt_gate) else $error("Streaming while disabled.");
    property p_led;
        @(posedge aclk) disable iff (!aresetn) (wr_fire && awaddr_q == rcc_pkg::OFF_CTRL) |=> led_q == $past(wv[2]);
    endproperty
    a_led: assert property (p_led) else $error("Indicator enable not applied.");
    c_vpp: cover property (@(posedge aclk) vpp_q && vpp_cnt_q == 33'h1);
    c_acc: cover property (@(posedge aclk) cfg_res_q == 2'h2);
    c_rej: cover property (@(posedge aclk) cfg_res_q == 2'h1);

endmodule

// >>> rtl/rcc_pkg.sv
package rcc_pkg;

    // Channel count and relay path encodings.
    localparam int unsigned NUM_CH = 6;
    typedef enum logic [1:0] {
        RCC_PATH_SIG   = 2'h0,
        RCC_PATH_LOOP  = 2'h1,
        RCC_PATH_SHORT = 2'h2
    } rcc_path_t;

    // Register byte offsets.
    localparam logic [7:0] OFF_RELAY   = 8'h00;
    localparam logic [7:0] OFF_CTRL    = 8'h04;
    localparam logic [7:0] OFF_CFG     = 8'h08;
    localparam logic [7:0] OFF_STATUS  = 8'h0c;
    localparam logic [7:0] OFF_IRQ_ST  = 8'h10;
    localparam logic [7:0] OFF_IRQ_MSK = 8'h14;

    // RELAY write: per channel two path bits at 2*i, enable at 16+i.
    localparam int unsigned RELAY_EN_POS = 16;
    // CTRL bits.
    localparam int unsigned CTRL_VPP_ON   = 0;
    localparam int unsigned CTRL_VPP_OFF  = 1;
    localparam int unsigned CTRL_LED_POS  = 2;
    localparam int unsigned CTRL_RT_POS   = 3;
    localparam int unsigned CTRL_CAL_DONE = 4;
    // CFG write: bit0 = upload arrived, bit1 = upload valid.
    localparam int unsigned CFG_ARRIVE = 0;
    localparam int unsigned CFG_VALID  = 1;
    // Interrupt bits.
    localparam int unsigned IRQ_VPP_EXP = 0;
    localparam int unsigned IRQ_CFG_ACK = 1;
    localparam int unsigned IRQ_CFG_NAK = 2;
    localparam int unsigned IRQ_CAL_RET = 3;
    localparam int unsigned IRQ_W       = 4;

    // Reset values.
    localparam logic RST_LED = 1'b1;
    localparam logic RST_RT  = 1'b1;

    // Test supply timing.
    localparam longint unsigned CLK_HZ      = 40000000;
    localparam longint unsigned VPP_TIME_S  = 120;
    localparam longint unsigned VPP_CYCLES  = VPP_TIME_S * CLK_HZ;
    localparam int unsigned     VPP_CNT_W   = 33;
    localparam int unsigned     WARM_CYCLES = 16;

    // Outputs toward the recorder.
    typedef struct packed {
        logic                    vpp_en;
        logic                    led_en;
        logic                    rt_en;
        logic                    warm_rst;
        logic                    offset_cal;
        logic [2*NUM_CH-1:0]     relay_sel;
    } rcc_out_t;

endpackage

// >>> tb/rcc_src_model.sv
`timescale 1ns/1ps
// Acquisition source: one tagged word per cycle while go is high.
module rcc_src_model (
    input  wire logic        aclk,
    input  wire logic        go,
    output logic             rt_data_valid,
    output logic [31:0]      rt_data
);
    logic [7:0] seq_q;

    initial begin
        rt_data_valid = 1'b0;
        rt_data       = 32'h0;
        seq_q         = 8'h0;
    end

    // Between words the data lines toggle, so a stale word is never mistaken for a fresh one.
    always @(posedge aclk) begin
        rt_data_valid <= go;
        rt_data       <= go ? {24'ha50000, seq_q} : ~rt_data;
        if (go) seq_q <= seq_q + 8'h1;
    end
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam int VPP_N = 50;
    logic        aclk = 1'b0, aresetn = 1'b0, go = 1'b0;
    logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rd, rdata, rt_data, tx_data, last_tx;
    logic [1:0]  bresp, rresp, resp;
    logic        awready, wready, bvalid, arready, rvalid, rt_data_valid, tx_data_valid, irq;
    rcc_pkg::rcc_out_t ctl;
    int          fail_count = 0, n_tests = 0, cyc = 0, warm_n = 0, ofs_n = 0, tx_n = 0;

    always #12.5 aclk = ~aclk;

    rcc_top #(.VPP_CYCLES_P(33'(VPP_N))) DUT (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rt_data_valid(rt_data_valid),
        .rt_data(rt_data), .tx_data_valid(tx_data_valid), .tx_data(tx_data), .ctl_out(ctl), .irq(irq));

    rcc_src_model src (.aclk(aclk), .go(go), .rt_data_valid(rt_data_valid), .rt_data(rt_data));

    // Pulse widths and streamed words are counted here, so short pulses are never missed.
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (ctl.warm_rst === 1'b1) warm_n <= warm_n + 1;
        if (ctl.offset_cal === 1'b1) ofs_n <= ofs_n + 1;
        if (tx_data_valid === 1'b1) begin
            tx_n    <= tx_n + 1;
            last_tx <= tx_data;
        end
        if (cyc == 5000) begin
            fail_count = fail_count + 1;
            end_sim();
        end
    end

    task automatic end_sim();
        if (fail_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Address and data are offered together and each is dropped once taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok  = 1'b0;
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1 && !aw_ok) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready === 1'b1 && !w_ok) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end while (!(aw_ok && w_ok));
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
        // One idle edge, so a following call never raises bready in the same time step.
        @(posedge aclk);
    endtask

    task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        // One idle edge, so a following call never raises rready in the same time step.
        @(posedge aclk);
    endtask

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rdr(rcc_pkg::OFF_CTRL, rd, resp);   chk("ctrl reset", 32'h0c, rd);
        rdr(rcc_pkg::OFF_RELAY, rd, resp);  chk("relay reset", 32'h0, rd);
        // Loopback is only used here the way calibration would use it.
        wr(rcc_pkg::OFF_RELAY, 32'h0003_0026, resp);
        chk("relay sel", 32'h006, {20'h0, ctl.relay_sel});
        wr(rcc_pkg::OFF_RELAY, 32'h0001_002b, resp); // Code 3 on enabled channel 0 is dropped.
        rdr(rcc_pkg::OFF_RELAY, rd, resp);  chk("relay held", 32'h6, rd);
        wr(rcc_pkg::OFF_CTRL, 32'h1c, resp);
        chk("relay after cal", 32'h0, {20'h0, ctl.relay_sel});
        repeat (2) @(posedge aclk);
        chk("irq masked", 32'h0, {31'h0, irq});
        rdr(rcc_pkg::OFF_IRQ_ST, rd, resp); chk("cal event", 32'h8, rd);
        wr(rcc_pkg::OFF_CTRL, 32'h08, resp);
        chk("led off", 32'h0, {31'h0, ctl.led_en});
        chk("rt kept", 32'h1, {31'h0, ctl.rt_en});
        wr(rcc_pkg::OFF_CTRL, 32'h0c, resp);
        chk("led on", 32'h1, {31'h0, ctl.led_en});
        go <= 1'b1;
        repeat (4) @(posedge aclk);
        go <= 1'b0;
        repeat (3) @(posedge aclk);
        chk("tx count", 32'd4, 32'(tx_n));
        chk("tx word", 32'ha500_0003, last_tx);
        // Streaming is stopped before the upload to free the link.
        wr(rcc_pkg::OFF_CTRL, 32'h04, resp);
        go <= 1'b1;
        repeat (4) @(posedge aclk);
        go <= 1'b0;
        repeat (3) @(posedge aclk);
        chk("tx stopped", 32'd4, 32'(tx_n));
        wr(rcc_pkg::OFF_IRQ_MSK, 32'hf, resp);
        wr(rcc_pkg::OFF_CFG, 32'h3, resp);
        repeat (20) @(posedge aclk);
        chk("warm width", 32'(rcc_pkg::WARM_CYCLES), 32'(warm_n));
        chk("offset cal", 32'd1, 32'(ofs_n));
        chk("irq accept", 32'h1, {31'h0, irq});
        rdr(rcc_pkg::OFF_CFG, rd, resp);    chk("cfg accept", 32'h2, rd);
        rdr(rcc_pkg::OFF_IRQ_ST, rd, resp); chk("ack event", 32'h2, rd);
        repeat (2) @(posedge aclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        wr(rcc_pkg::OFF_CFG, 32'h1, resp);
        repeat (20) @(posedge aclk);
        chk("no warm", 32'(rcc_pkg::WARM_CYCLES), 32'(warm_n));
        rdr(rcc_pkg::OFF_CFG, rd, resp);    chk("cfg reject", 32'h1, rd);
        rdr(rcc_pkg::OFF_IRQ_ST, rd, resp); chk("nak event", 32'h4, rd);
        // A second On at mid-count must push expiry past the first deadline.
        wr(rcc_pkg::OFF_CTRL, 32'h0d, resp);
        chk("vpp on", 32'h1, {31'h0, ctl.vpp_en});
        repeat (30) @(posedge aclk);
        wr(rcc_pkg::OFF_CTRL, 32'h0d, resp);
        repeat (30) @(posedge aclk);
        chk("vpp restarted", 32'h1, {31'h0, ctl.vpp_en});
        repeat (30) @(posedge aclk);
        chk("vpp expired", 32'h0, {31'h0, ctl.vpp_en});
        rdr(rcc_pkg::OFF_IRQ_ST, rd, resp); chk("vpp event", 32'h1, rd);
        wr(rcc_pkg::OFF_CTRL, 32'h0d, resp);
        wr(rcc_pkg::OFF_CTRL, 32'h0e, resp);
        chk("vpp off", 32'h0, {31'h0, ctl.vpp_en});
        rdr(rcc_pkg::OFF_STATUS, rd, resp); chk("countdown cleared", 32'h0, rd);
        repeat (70) @(posedge aclk);
        rdr(rcc_pkg::OFF_IRQ_ST, rd, resp); chk("no expiry", 32'h0, rd);
        rdr(8'h18, rd, resp);               chk("unmapped", 32'h2, {30'h0, resp});
        wr(rcc_pkg::OFF_STATUS, 32'h0, resp);
        chk("status ro", 32'h2, {30'h0, resp});
        end_sim();
    end
endmodule
